// ===== src/ssr_pkg.sv
// shared constants and types for the serial slave register access block
package ssr_pkg;

    // ----------------------------------------
    // slave address and framing
    // ----------------------------------------
    localparam logic [3:0] SLAVE_ADDR_FIXED = 4'ha;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [2:0] TX_LAST_BIT      = 3'h7;

    // ----------------------------------------
    // memory map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CONTROL_ADDR      = 8'hb7;
    localparam int         HALT_BIT          = 0;
    localparam logic [7:0] PW_ENTRY_BASE     = 8'hbc;
    localparam logic [7:0] STORED_PW_BASE    = 8'hc2;
    localparam logic [7:0] BIAS_DAC_ADDR     = 8'hd1;
    localparam logic [7:0] MOD_DAC_ADDR_HI   = 8'hd6;
    localparam logic [7:0] MOD_DAC_ADDR_LO   = 8'hd7;
    localparam logic [7:0] MOD_DAC_LO_MASK   = 8'hf0;
    localparam logic [7:0] ROW_MASK          = 8'hf8;
    localparam logic [2:0] ROW_INDEX_MASK    = 3'h7;

    // ----------------------------------------
    // reset values and the value a refused read returns
    // ----------------------------------------
    localparam logic [7:0] MEM_RESET         = 8'h00;
    localparam logic [7:0] PW_ENTRY_RESET    = 8'hff;
    localparam logic [7:0] REFUSED_READ      = 8'h00;
    localparam logic [7:0] ADDR_CNT_RESET    = 8'h00;

    // ----------------------------------------
    // nonvolatile commit time in cycles
    // ----------------------------------------
    localparam int         EE_WRITE_CYCLES   = 62500;

    // ----------------------------------------
    // carrier types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } ssr_wr_s;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SLAVE_ADDR,
        ST_MEM_ADDR,
        ST_WR_DATA,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } ssr_state_e;

endpackage

// ===== src/ssr_top.sv
// two-wire slave port with byte memory, password gating and write fifo

// ----------------------------------------
// fifo
// ----------------------------------------
module ssr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out  = store_r[rd_ptr_r];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_ff @(posedge mclk_in) begin
        if (push) begin
            store_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------
// slave port
// ----------------------------------------
module ssr_top #(
    parameter int FIFO_DEPTH      = 8,
    parameter int EE_WRITE_CYCLES = ssr_pkg::EE_WRITE_CYCLES
) (
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    input  wire logic addr_select_bit2_in,
    input  wire logic addr_select_bit1_in,
    input  wire logic addr_select_bit0_in,
    output logic      loop_halt_out,
    output logic      commit_busy_out
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_raw;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] sync3_r;
    logic [4:0] pin_f_r;

    assign pin_raw = {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in,
                      sda_in, scl_in};

    // a change counts only once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                    sync3_r[gi] <= 1'b1;
                    pin_f_r[gi] <= 1'b1;
                end else begin
                    sync1_r[gi] <= pin_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        pin_f_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // bus events
    // ----------------------------------------
    logic scl_q_r;
    logic sda_q_r;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_f      = pin_f_r[0];
    assign sda_f      = pin_f_r[1];
    assign scl_rise   = scl_f & ~scl_q_r;
    assign scl_fall   = ~scl_f & scl_q_r;
    assign start_cond = scl_f & scl_q_r & sda_q_r & ~sda_f;
    assign stop_cond  = scl_f & scl_q_r & ~sda_q_r & sda_f;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_f;
            sda_q_r <= sda_f;
        end
    end

    // ----------------------------------------
    // memory and access gating
    // ----------------------------------------
    logic [7:0]      mem_r [256];
    logic [31:0]     pw_entry;
    logic [31:0]     pw_stored;
    logic            unlocked;
    logic            halted;
    logic [7:0]      addr_cnt_r;
    ssr_pkg::ssr_wr_s fifo_in;
    ssr_pkg::ssr_wr_s fifo_out;
    logic            fifo_in_valid;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic            fifo_out_ready;
    logic            read_load;

    assign pw_entry  = {mem_r[ssr_pkg::PW_ENTRY_BASE], mem_r[ssr_pkg::PW_ENTRY_BASE + 8'h1],
                        mem_r[ssr_pkg::PW_ENTRY_BASE + 8'h2],
                        mem_r[ssr_pkg::PW_ENTRY_BASE + 8'h3]};
    assign pw_stored = {mem_r[ssr_pkg::STORED_PW_BASE], mem_r[ssr_pkg::STORED_PW_BASE + 8'h1],
                        mem_r[ssr_pkg::STORED_PW_BASE + 8'h2],
                        mem_r[ssr_pkg::STORED_PW_BASE + 8'h3]};
    assign unlocked      = (pw_entry == pw_stored);
    assign halted        = mem_r[ssr_pkg::CONTROL_ADDR][ssr_pkg::HALT_BIT];
    assign loop_halt_out = halted;

    function automatic logic is_pw_entry(input logic [7:0] a);
        is_pw_entry = (a >= ssr_pkg::PW_ENTRY_BASE) && (a <= ssr_pkg::PW_ENTRY_BASE + 8'h3);
    endfunction

    function automatic logic is_volatile(input logic [7:0] a);
        is_volatile = is_pw_entry(a) || (a == ssr_pkg::BIAS_DAC_ADDR) ||
                      (a == ssr_pkg::MOD_DAC_ADDR_HI) || (a == ssr_pkg::MOD_DAC_ADDR_LO);
    endfunction

    // read view of one location with its gating applied
    function automatic logic [7:0] read_view(input logic [7:0] a, input logic unl,
                                             input logic hlt, input logic [7:0] raw);
        if ((a >= ssr_pkg::STORED_PW_BASE) && (a <= ssr_pkg::STORED_PW_BASE + 8'h3)) begin
            read_view = unl ? raw : ssr_pkg::REFUSED_READ;
        end else if (a == ssr_pkg::BIAS_DAC_ADDR) begin
            read_view = (unl && hlt) ? raw : ssr_pkg::REFUSED_READ;
        end else if (a == ssr_pkg::MOD_DAC_ADDR_HI) begin
            read_view = (unl && hlt) ? raw : ssr_pkg::REFUSED_READ;
        end else if (a == ssr_pkg::MOD_DAC_ADDR_LO) begin
            read_view = (unl && hlt) ? (raw & ssr_pkg::MOD_DAC_LO_MASK)
                                     : ssr_pkg::REFUSED_READ;
        end else begin
            read_view = raw;
        end
    endfunction

    // drain yields the memory port to a read byte load
    assign fifo_out_ready = ~read_load;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 256; i++) begin
                mem_r[i] <= ssr_pkg::MEM_RESET;
            end
            for (int i = 0; i < 4; i++) begin
                mem_r[ssr_pkg::PW_ENTRY_BASE + 8'(i)] <= ssr_pkg::PW_ENTRY_RESET;
            end
        end else if (fifo_out_valid && fifo_out_ready) begin
            if (unlocked || is_pw_entry(fifo_out.addr)) begin
                mem_r[fifo_out.addr] <= fifo_out.data;
            end
        end
    end

    ssr_fifo #(
        .WIDTH ($bits(ssr_pkg::ssr_wr_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out)
    );

    // ----------------------------------------
    // byte engine
    // ----------------------------------------
    ssr_pkg::ssr_state_e state_r;
    ssr_pkg::ssr_state_e ack_next_r;
    logic [7:0]          shift_r;
    logic [3:0]          bit_cnt_r;
    logic                sda_oe_r;
    logic                rw_r;
    logic                master_ack_r;
    logic                dirty_r;
    logic [31:0]         busy_cnt_r;
    logic                busy;
    logic                addr_match;
    logic [7:0]          rd_byte;
    logic [7:0]          wr_addr_nxt;

    assign busy            = (busy_cnt_r != '0);
    assign commit_busy_out = busy;
    assign sda_out         = 1'b0;
    assign sda_oe_out      = sda_oe_r;
    assign addr_match      = (shift_r[7:1] == {ssr_pkg::SLAVE_ADDR_FIXED, pin_f_r[4:2]});
    assign rd_byte         = read_view(addr_cnt_r, unlocked, halted, mem_r[addr_cnt_r]);
    assign read_load       = scl_fall && ((state_r == ssr_pkg::ST_ACK && ack_next_r ==
                             ssr_pkg::ST_TX) || (state_r == ssr_pkg::ST_TX_ACK && master_ack_r));
    assign wr_addr_nxt     = (addr_cnt_r & ssr_pkg::ROW_MASK) |
                             {5'h00, (addr_cnt_r[2:0] + 3'h1) & ssr_pkg::ROW_INDEX_MASK};
    assign fifo_in.addr    = addr_cnt_r;
    assign fifo_in.data    = shift_r;
    assign fifo_in_valid   = scl_fall && (state_r == ssr_pkg::ST_WR_DATA) &&
                             (bit_cnt_r == ssr_pkg::BITS_PER_BYTE);

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_r      <= ssr_pkg::ST_IDLE;
            ack_next_r   <= ssr_pkg::ST_IDLE;
            shift_r      <= '0;
            bit_cnt_r    <= '0;
            sda_oe_r     <= 1'b0;
            rw_r         <= 1'b0;
            master_ack_r <= 1'b0;
            addr_cnt_r   <= ssr_pkg::ADDR_CNT_RESET;
        end else if (start_cond) begin
            state_r   <= ssr_pkg::ST_SLAVE_ADDR;
            bit_cnt_r <= '0;
            sda_oe_r  <= 1'b0;
        end else if (stop_cond) begin
            state_r   <= ssr_pkg::ST_IDLE;
            bit_cnt_r <= '0;
            sda_oe_r  <= 1'b0;
        end else begin
            case (state_r)
                ssr_pkg::ST_SLAVE_ADDR, ssr_pkg::ST_MEM_ADDR, ssr_pkg::ST_WR_DATA: begin
                    if (scl_rise && bit_cnt_r != ssr_pkg::BITS_PER_BYTE) begin
                        shift_r   <= {shift_r[6:0], sda_f};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == ssr_pkg::BITS_PER_BYTE) begin
                        state_r <= ssr_pkg::ST_ACK;
                        if (state_r == ssr_pkg::ST_SLAVE_ADDR) begin
                            rw_r <= shift_r[0];
                            if (addr_match && !busy) begin
                                sda_oe_r   <= 1'b1;
                                ack_next_r <= shift_r[0] ? ssr_pkg::ST_TX
                                                         : ssr_pkg::ST_MEM_ADDR;
                            end else begin
                                state_r <= ssr_pkg::ST_IGNORE;
                            end
                        end else if (state_r == ssr_pkg::ST_MEM_ADDR) begin
                            addr_cnt_r <= shift_r;
                            sda_oe_r   <= 1'b1;
                            ack_next_r <= ssr_pkg::ST_WR_DATA;
                        end else begin
                            // a full fifo answers with a nack and drops the byte
                            sda_oe_r   <= fifo_in_ready;
                            ack_next_r <= ssr_pkg::ST_WR_DATA;
                            if (fifo_in_ready) begin
                                addr_cnt_r <= wr_addr_nxt;
                            end
                        end
                    end
                end
                ssr_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= '0;
                        state_r   <= ack_next_r;
                        if (ack_next_r == ssr_pkg::ST_TX) begin
                            shift_r    <= {rd_byte[6:0], 1'b0};
                            sda_oe_r   <= ~rd_byte[7];
                            addr_cnt_r <= addr_cnt_r + 8'h1;
                        end else begin
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                ssr_pkg::ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r[2:0] == ssr_pkg::TX_LAST_BIT) begin
                            sda_oe_r <= 1'b0;
                            state_r  <= ssr_pkg::ST_TX_ACK;
                        end else begin
                            sda_oe_r <= ~shift_r[7];
                            shift_r  <= {shift_r[6:0], 1'b0};
                        end
                    end
                end
                ssr_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        master_ack_r <= ~sda_f;
                    end else if (scl_fall) begin
                        bit_cnt_r <= '0;
                        if (master_ack_r) begin
                            shift_r    <= {rd_byte[6:0], 1'b0};
                            sda_oe_r   <= ~rd_byte[7];
                            addr_cnt_r <= addr_cnt_r + 8'h1;
                            state_r    <= ssr_pkg::ST_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r  <= ssr_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // row commit timer
    // ----------------------------------------
    // any write accepted while unlocked outside the volatile bytes wears a row and costs a commit
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            dirty_r    <= 1'b0;
            busy_cnt_r <= '0;
        end else begin
            if (stop_cond && dirty_r) begin
                busy_cnt_r <= 32'(EE_WRITE_CYCLES);
            end else if (busy) begin
                busy_cnt_r <= busy_cnt_r - 32'h1;
            end
            if (stop_cond) begin
                dirty_r <= 1'b0;
            end else if (fifo_in_valid && fifo_in_ready && unlocked &&
                         !is_volatile(addr_cnt_r)) begin
                dirty_r <= 1'b1;
            end
        end
    end

endmodule

// ===== sim/ssr_top_assertions.sv
// pin-level checker for the serial slave port
module ssr_top_assertions #(
    parameter int EE_WRITE_CYCLES = 20
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic addr_select_bit2_in,
    input wire logic addr_select_bit1_in,
    input wire logic addr_select_bit0_in,
    input wire logic loop_halt_out,
    input wire logic commit_busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // commit length counter
    // ----------------------------------------
    int busy_cnt_r;
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || !commit_busy_out) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    chk_rst_quiet: assert property (disable iff (1'b0)
        sys_rst_in |=> !sda_oe_out && !commit_busy_out && !loop_halt_out)
        else $error("outputs active after reset");
    chk_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin value not low");
    chk_oe_when_low: assert property (
        $changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
        else $error("data drive changed outside clock low");
    chk_oe_stable_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("data drive changed while clock high");
    chk_start_quiet: assert property (
        scl_in && $past(scl_in) && $fell(sda_in) |=> !sda_oe_out [*8])
        else $error("data driven right after start");
    chk_stop_quiet: assert property (
        scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe_out [*8])
        else $error("data driven right after stop");
    chk_busy_idle: assert property ($rose(commit_busy_out) |-> scl_in && sda_in)
        else $error("commit began with bus not idle");
    chk_busy_no_ack: assert property (commit_busy_out |-> !$rose(sda_oe_out))
        else $error("acknowledge during commit");
    chk_busy_len: assert property (
        $fell(commit_busy_out) |-> busy_cnt_r == EE_WRITE_CYCLES)
        else $error("commit length wrong");

    cover property ($rose(commit_busy_out));
    cover property ($rose(sda_oe_out));
    cover property ($rose(loop_halt_out));
endmodule

bind ssr_top ssr_top_assertions #(.EE_WRITE_CYCLES(EE_WRITE_CYCLES)) u_chk (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_select_bit2_in(addr_select_bit2_in),
    .addr_select_bit1_in(addr_select_bit1_in), .addr_select_bit0_in(addr_select_bit0_in),
    .loop_halt_out(loop_halt_out), .commit_busy_out(commit_busy_out));

// ===== sim/ssr_bus_master.sv
// behavioural two-wire bus master facing the slave port
module ssr_bus_master (
    output logic       scl_out,
    output logic       sda_low_out,
    input  wire logic  sda_in,
    output logic [7:0] res_out,
    output logic       res_stb_out
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam real Q = 31.25;

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        res_out = 8'h00;
        res_stb_out = 1'b0;
    end

    // one bit slot, entered just after a clock fall; a 1 releases the line
    task automatic bit_io(input logic b, output logic s);
        #Q sda_low_out = !b;
        #Q scl_out = 1'b1;
        #Q s = sda_in;
        #Q scl_out = 1'b0;
    endtask

    // also serves as repeated start
    task automatic bus_start();
        #Q sda_low_out = 1'b0;
        #Q scl_out = 1'b1;
        #Q sda_low_out = 1'b1;
        #Q scl_out = 1'b0;
    endtask

    task automatic bus_stop();
        #Q sda_low_out = 1'b1;
        #Q scl_out = 1'b1;
        #Q sda_low_out = 1'b0;
        #Q;
    endtask

    task automatic emit(input logic [7:0] v);
        res_out = v;
        res_stb_out = 1'b1;
        #1 res_stb_out = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(b[i], a);
        bit_io(1'b1, a);
        emit({7'h00, a});
    endtask

    task automatic get_byte(input logic last);
        logic [7:0] d;
        logic       a;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, a);
        emit(d);
    endtask
endmodule

// ===== sim/ssr_top_tb.sv
// self-checking bench for the serial slave port
module ssr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int EE_CYC = 250;
    localparam int LIMIT  = 40000;

    logic       mclk = 1'b0;
    logic       rst  = 1'b1;
    logic [2:0] sel  = 3'h0;
    logic       scl, sda_low, sda_oe, sda_drv, halt, busy, stb;
    logic [7:0] res, r, b, mh, ml;
    logic [7:0] dw[3];
    logic [7:0] exp_q[$];
    int         error_cnt, n_compared, cyc;
    int         seed = 72;
    // pull-up: released line reads high
    wire        sda_line = !(sda_low | sda_oe);

    always #4 mclk = ~mclk;

    ssr_top #(.FIFO_DEPTH(8), .EE_WRITE_CYCLES(EE_CYC)) DUT (
        .mclk_in(mclk), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .addr_select_bit2_in(sel[2]),
        .addr_select_bit1_in(sel[1]), .addr_select_bit0_in(sel[0]),
        .loop_halt_out(halt), .commit_busy_out(busy));
    ssr_bus_master u_master (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_line),
        .res_out(res), .res_stb_out(stb));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // every byte slot of the master yields one result
    always @(posedge stb) check(res, exp_q.pop_front());

    function automatic logic [7:0] sa(input logic rd_n);
        return {ssr_pkg::SLAVE_ADDR_FIXED, sel, rd_n};
    endfunction

    task automatic wb(input logic [7:0] v, input logic [7:0] ack);
        exp_q.push_back(ack);
        u_master.put_byte(v);
    endtask

    task automatic rb(input logic last, input logic [7:0] e);
        exp_q.push_back(e);
        u_master.get_byte(last);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] d[$]);
        u_master.bus_start();
        wb(sa(1'b0), 8'h00);
        wb(addr, 8'h00);
        foreach (d[i]) wb(d[i], 8'h00);
        u_master.bus_stop();
    endtask

    task automatic rd_on(input logic [7:0] e[$]);
        wb(sa(1'b1), 8'h00);
        foreach (e[i]) rb(i == e.size() - 1, e[i]);
        u_master.bus_stop();
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] e[$]);
        u_master.bus_start();
        wb(sa(1'b0), 8'h00);
        wb(addr, 8'h00);
        u_master.bus_start();
        rd_on(e);
    endtask

    // address polling while a row commits, then wait it out
    task automatic poll_busy();
        u_master.bus_start();
        wb(sa(1'b0), 8'h01);
        u_master.bus_stop();
        // look just after the edge so the design's update has landed
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        check({7'h00, busy}, 8'h00);
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        sel = 3'($random(seed));
        r = 8'($random(seed)) | 8'h01;
        b = 8'($random(seed));
        mh = 8'($random(seed));
        ml = 8'($random(seed));
        foreach (dw[i]) dw[i] = 8'($random(seed));
        repeat (4) @(posedge mclk);
        u_master.bus_start();
        wb({ssr_pkg::SLAVE_ADDR_FIXED, ~sel, 1'b0}, 8'h01);
        wb(8'h10, 8'h01);
        u_master.bus_stop();
        $display("test foreign address done");
        wr(8'h10, '{r});
        rd(8'h10, '{8'h00});
        $display("test locked write done");
        wr(8'hbc, '{8'h00, 8'h00, 8'h00, 8'h00});
        wr(8'hc5, '{r});
        poll_busy();
        rd(8'hc4, '{8'h00, 8'h00});
        wr(8'hbf, '{r});
        rd(8'hc4, '{8'h00, r});
        $display("test password done");
        wr(8'h0e, '{dw[0], dw[1], dw[2]});
        poll_busy();
        rd(8'h0e, '{dw[0], dw[1]});
        u_master.bus_start();
        rd_on('{8'h00});
        rd(8'h08, '{dw[2]});
        $display("test row wrap done");
        wr(8'hd1, '{b});
        wr(8'hd6, '{mh, ml});
        rd(8'hd1, '{8'h00});
        wr(8'hb7, '{8'h01});
        poll_busy();
        check({7'h00, halt}, 8'h01);
        rd(8'hd1, '{b});
        rd(8'hd6, '{mh, ml & 8'hf0});
        wr(8'hbf, '{~r});
        rd(8'hd1, '{8'h00});
        $display("test dac gating done");
        give_verdict();
    end
endmodule
